// [rtl/brtc_pkg.sv]
// shared constants, types and register map of the bytewide rtc with nvram
package brtc_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  // clock registers sit at the eight highest addresses
  localparam logic [12:0] CLK_BASE    = 13'h1ff8;
  localparam logic [2:0]  REG_CTRL    = 3'h0;
  localparam logic [2:0]  REG_SEC     = 3'h1;
  localparam logic [2:0]  REG_MIN     = 3'h2;
  localparam logic [2:0]  REG_HOUR    = 3'h3;
  localparam logic [2:0]  REG_DAY     = 3'h4;
  localparam logic [2:0]  REG_DATE    = 3'h5;
  localparam logic [2:0]  REG_MONTH   = 3'h6;
  localparam logic [2:0]  REG_YEAR    = 3'h7;
  localparam int          CTRL_LOAD_BIT = 7;
  localparam int          CTRL_HOLD_BIT = 6;
  // writable bits per register, the rest are stored as zero
  localparam logic [7:0]  MASK_SEC    = 8'h7f;
  localparam logic [7:0]  MASK_MIN    = 8'h7f;
  localparam logic [7:0]  MASK_HOUR   = 8'h3f;
  localparam logic [7:0]  MASK_DAY    = 8'h07;
  localparam logic [7:0]  MASK_DATE   = 8'h3f;
  localparam logic [7:0]  MASK_MONTH  = 8'h1f;
  // bcd limits
  localparam logic [7:0]  LAST_SEC    = 8'h59;
  localparam logic [7:0]  LAST_HOUR   = 8'h23;
  localparam logic [7:0]  LAST_DAY    = 8'h07;
  localparam logic [7:0]  LAST_MONTH  = 8'h12;
  localparam logic [7:0]  LAST_YEAR   = 8'h99;
  localparam logic [7:0]  LAST_CENT   = 8'h39;
  localparam logic [7:0]  FIRST_ZERO  = 8'h00;
  localparam logic [7:0]  FIRST_ONE   = 8'h01;
  // values after reset
  localparam logic [7:0]  RST_TIME    = 8'h00;
  localparam logic [7:0]  RST_CAL     = 8'h01;
  // timing
  localparam int CLK_HZ               = 50_000_000;
  localparam int RECOVERY_LOCKOUT_MS  = 10;
  localparam int TICK_CYCLES_DEF      = CLK_HZ;
  localparam int LOCK_CYCLES_DEF      = (CLK_HZ / 1000) * RECOVERY_LOCKOUT_MS;

  typedef struct packed {
    logic [5:0] cent;
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } brtc_time_t;

  typedef struct packed {
    logic              pwr_ok;
    logic              ce_n;
    logic              sel_hi;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } brtc_pins_t;

  typedef enum logic [1:0] {
    BRTC_IDLE  = 2'b00,
    BRTC_WRITE = 2'b01,
    BRTC_LOCK  = 2'b10
  } brtc_bus_t;

  typedef struct packed {
    brtc_pins_t        s1;
    brtc_pins_t        s2;
    brtc_pins_t        s3;
    brtc_pins_t        filt;
    brtc_bus_t         bus;
    logic [31:0]       lock_cnt;
    logic [31:0]       tick_cnt;
    brtc_time_t        cnt;
    brtc_time_t        vis;
    logic              load;
    logic              hold;
    logic              ram_we;
    logic [ADDR_W-1:0] wa;
    logic [DATA_W-1:0] wd;
    logic [DATA_W-1:0] rd;
    logic              oe;
  } brtc_state_t;
endpackage

// [rtl/brtc_top.sv]
// bytewide real-time clock with battery-backed 8k x 8 static ram
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - 8192 bytes, clock registers at top eight
// - one byte-wide bus reaches ram and clock
// - bcd century to seconds, 24-hour count
// - month lengths and leap years handled automatically
// - double buffering never stalls internal count
// - supply out of tolerance blocks all access
// - access stays blocked for recovery lockout
// - day of week advances at midnight sequentially
// - hold bit 6 freezes visible registers
// - frozen view, internal count keeps running
// - all visible registers refresh together after hold
// - load bit 7 halts updates for setting
// - clearing load copies written time into counters
// - clearing hold resumes from internal count
// - setting load or hold keeps century
// - clearing load with hold also clear writes century field
// - clearing only hold keeps century
// - selected, oe low, we high drives data
// - we and selects active perform write
module brtc_top
  import brtc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int LOCK_CYCLES = LOCK_CYCLES_DEF
) (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              power_ok,
  input  wire logic              chip_sel_n,
  input  wire logic              second_select_hi,
  input  wire logic              out_en_n,
  input  wire logic              wr_en_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [DATA_W-1:0] dq_out,
  output logic                   dq_oe
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // bcd increment with wrap; bit 8 is the carry out
  function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] last,
                                         input logic [7:0] first);
    logic [8:0] res;
    if (v == last) begin
      res = {1'b1, first};
    end else if (v[3:0] == 4'h9) begin
      res = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      res = {1'b0, v + 8'h01};
    end
    return res;
  endfunction

  // two-digit bcd year divisible by four; year 00 counts as leap
  function automatic logic is_leap(input logic [7:0] y);
    logic res;
    if (y[4]) begin
      res = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      res = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
    return res;
  endfunction

  function automatic logic [7:0] month_last(input logic [7:0] m,
                                            input logic [7:0] y);
    logic [7:0] res;
    case (m)
      8'h02:                      res = is_leap(y) ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: res = 8'h30;
      default:                    res = 8'h31;
    endcase
    return res;
  endfunction

  function automatic logic in_clock_space(input logic [ADDR_W-1:0] a);
    return a >= CLK_BASE;
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // battery-backed contents: no reset, survives srst
  logic [DATA_W-1:0] ram [0:(1<<ADDR_W)-1];

  brtc_state_t r;
  brtc_state_t n;
  brtc_pins_t  pins;
  logic        sel;
  logic        wr_act;
  logic        tick;
  logic [8:0]  c;
  logic [7:0]  rdv;
  logic [7:0]  d;

  assign pins = '{pwr_ok: power_ok, ce_n: chip_sel_n, sel_hi: second_select_hi,
                  oe_n: out_en_n, we_n: wr_en_n, addr: addr, data: dq_in};

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n        = r;
    c        = 9'h000;
    rdv      = 8'h00;
    d        = r.wd;
    n.ram_we = 1'b0;

    // pin synchronisers, a change counts once stages two and three agree
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) begin
      n.filt = r.s3;
    end

    // selection is forced off while the supply is low or locked out
    sel    = !r.filt.ce_n && r.filt.sel_hi && r.filt.pwr_ok
             && (r.bus != BRTC_LOCK);
    wr_act = sel && !r.filt.we_n;

    // seconds prescaler, never paused by host traffic
    tick       = (r.tick_cnt == 32'(TICK_CYCLES - 1));
    n.tick_cnt = tick ? 32'h0 : r.tick_cnt + 32'h1;

    // internal count
    if (tick) begin
      c         = bcd_inc(r.cnt.sec, LAST_SEC, FIRST_ZERO);
      n.cnt.sec = c[7:0];
      if (c[8]) begin
        c         = bcd_inc(r.cnt.min, LAST_SEC, FIRST_ZERO);
        n.cnt.min = c[7:0];
        if (c[8]) begin
          c          = bcd_inc(r.cnt.hour, LAST_HOUR, FIRST_ZERO);
          n.cnt.hour = c[7:0];
          if (c[8]) begin
            c         = bcd_inc(r.cnt.day, LAST_DAY, FIRST_ONE);
            n.cnt.day = c[7:0];
            c          = bcd_inc(r.cnt.date,
                                 month_last(r.cnt.month, r.cnt.year),
                                 FIRST_ONE);
            n.cnt.date = c[7:0];
            if (c[8]) begin
              c           = bcd_inc(r.cnt.month, LAST_MONTH, FIRST_ONE);
              n.cnt.month = c[7:0];
              if (c[8]) begin
                c          = bcd_inc(r.cnt.year, LAST_YEAR, FIRST_ZERO);
                n.cnt.year = c[7:0];
                if (c[8]) begin
                  c          = bcd_inc({2'b00, r.cnt.cent}, LAST_CENT, FIRST_ZERO);
                  n.cnt.cent = c[5:0];
                end
              end
            end
          end
        end
      end
    end

    // visible copy follows the count every cycle unless halted, so a
    // release is seen well inside one second and all fields move at once
    if (!r.load && !r.hold) begin
      n.vis = r.cnt;
    end

    // host bus sequencing
    case (r.bus)
      BRTC_LOCK: begin
        n.lock_cnt = r.lock_cnt + 32'h1;
        if (!r.filt.pwr_ok) begin
          n.lock_cnt = 32'h0;
        end else if (r.lock_cnt >= 32'(LOCK_CYCLES - 1)) begin
          n.bus = BRTC_IDLE;
        end
      end
      BRTC_IDLE: begin
        if (!r.filt.pwr_ok) begin
          n.bus      = BRTC_LOCK;
          n.lock_cnt = 32'h0;
        end else if (wr_act) begin
          n.bus = BRTC_WRITE;
          n.wa  = r.filt.addr;
          n.wd  = r.filt.data;
        end
      end
      BRTC_WRITE: begin
        if (!r.filt.pwr_ok) begin
          // a write caught by a supply drop is dropped, not half done
          n.bus      = BRTC_LOCK;
          n.lock_cnt = 32'h0;
        end else if (wr_act) begin
          // data is taken at the end of the strobe, last value wins
          n.wa = r.filt.addr;
          n.wd = r.filt.data;
        end else begin
          n.bus = BRTC_IDLE;
          if (in_clock_space(r.wa)) begin
            case (r.wa[2:0])
              REG_CTRL: begin
                n.load = d[CTRL_LOAD_BIT];
                n.hold = d[CTRL_HOLD_BIT];
                if (!d[CTRL_LOAD_BIT] && !d[CTRL_HOLD_BIT] && r.load) begin
                  n.vis.cent = d[5:0];
                end
                // setting either bit or clearing only hold keeps century
              end
              REG_SEC:   n.vis.sec   = d & MASK_SEC;
              REG_MIN:   n.vis.min   = d & MASK_MIN;
              REG_HOUR:  n.vis.hour  = d & MASK_HOUR;
              REG_DAY:   n.vis.day   = d & MASK_DAY;
              REG_DATE:  n.vis.date  = d & MASK_DATE;
              REG_MONTH: n.vis.month = d & MASK_MONTH;
              default:   n.vis.year  = d;
            endcase
          end else begin
            n.ram_we = 1'b1;
          end
        end
      end
      default: begin
        n.bus      = BRTC_LOCK;
        n.lock_cnt = 32'h0;
      end
    endcase

    // load bit falling: written set-point goes into the counters and
    // the prescaler restarts so the first second is a full one
    if (r.load && !n.load) begin
      n.cnt      = n.vis;
      n.tick_cnt = 32'h0;
    end

    // read path; registered so the data pins come from flip-flops
    if (in_clock_space(r.filt.addr)) begin
      case (r.filt.addr[2:0])
        REG_CTRL:  rdv = {r.load, r.hold, r.vis.cent};
        REG_SEC:   rdv = r.vis.sec;
        REG_MIN:   rdv = r.vis.min;
        REG_HOUR:  rdv = r.vis.hour;
        REG_DAY:   rdv = r.vis.day;
        REG_DATE:  rdv = r.vis.date;
        REG_MONTH: rdv = r.vis.month;
        default:   rdv = r.vis.year;
      endcase
    end else begin
      rdv = ram[r.filt.addr];
    end
    n.rd = rdv;
    // oe high keeps the read cycle but the pins stay released
    n.oe = sel && r.filt.we_n && !r.filt.oe_n;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r          <= '0;
      r.bus      <= BRTC_LOCK;
      r.cnt.sec  <= RST_TIME;
      r.cnt.min  <= RST_TIME;
      r.cnt.hour <= RST_TIME;
      r.cnt.day  <= RST_CAL;
      r.cnt.date <= RST_CAL;
      r.cnt.month <= RST_CAL;
      r.cnt.year <= RST_TIME;
      r.cnt.cent <= RST_TIME[5:0];
      r.vis      <= '0;
    end else begin
      r <= n;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (r.ram_we) begin
      ram[r.wa] <= r.wd;
    end
  end

  assign dq_out = r.rd;
  assign dq_oe  = r.oe;

endmodule

`default_nettype wire

// [tb/brtc_top_assertions.sv]
// pin-level checks of the rtc bus
`timescale 1ns/1ns
`default_nettype none
module brtc_chk
  import brtc_pkg::*;
#(
  parameter int LOCK_CYCLES = 8
) (
  input wire logic              sys_clk,
  input wire logic              srst,
  input wire logic              power_ok,
  input wire logic              chip_sel_n,
  input wire logic              second_select_hi,
  input wire logic              out_en_n,
  input wire logic              wr_en_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_in,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic              dq_oe
);
  // ----------------
  // powered-up time
  // ----------------
  logic [15:0] up_r;
  always_ff @(posedge sys_clk) begin
    if (srst || !power_ok) begin
      up_r <= 16'h0000;
    end else if (up_r != 16'hffff) begin
      up_r <= up_r + 16'h0001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // margin of two cycles over the pin synchroniser latency
  sequence read_held;
    (!chip_sel_n && second_select_hi && !out_en_n && wr_en_n && power_ok)[*8];
  endsequence
  a_cs_deselect: assert property (chip_sel_n[*7] |-> !dq_oe)
    else $error("driving while cs high");
  a_sel2_deselect: assert property (!second_select_hi[*7] |-> !dq_oe)
    else $error("driving while sel low");
  a_oe_high_quiet: assert property (out_en_n[*7] |-> !dq_oe)
    else $error("driving with oe high");
  a_write_no_drive: assert property (!wr_en_n[*7] |-> !dq_oe)
    else $error("driving during write");
  a_power_cut: assert property (!power_ok[*7] |-> !dq_oe)
    else $error("driving with power low");
  a_lockout_quiet: assert property (int'(up_r) <= LOCK_CYCLES |-> !dq_oe)
    else $error("driving in lockout");
  a_read_drives: assert property (int'(up_r) > LOCK_CYCLES + 10 ##0 read_held |-> dq_oe)
    else $error("read not driven");
  a_oe_release: assert property ($rose(out_en_n) |-> ##[1:7] !dq_oe)
    else $error("bus not released");
endmodule
bind brtc_top brtc_chk #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.sys_clk(sys_clk), .srst(srst),
  .power_ok(power_ok), .chip_sel_n(chip_sel_n), .second_select_hi(second_select_hi),
  .out_en_n(out_en_n), .wr_en_n(wr_en_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
  .dq_oe(dq_oe));
`default_nettype wire

// [tb/brtc_host.sv]
// host processor model on the byte-wide bus
`timescale 1ns/1ns
`default_nettype none
module brtc_host
  import brtc_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic [DATA_W-1:0] dq_out,
  input  wire logic              dq_oe,
  output logic                   chip_sel_n,
  output logic                   second_select_hi,
  output logic                   out_en_n,
  output logic                   wr_en_n,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] dq_in
);
  initial begin
    chip_sel_n = 1'b1;
    second_select_hi = 1'b0;
    out_en_n = 1'b1;
    wr_en_n = 1'b1;
    addr = 13'h0000;
    dq_in = 8'h00;
  end
  // address held over the whole cycle, strobe gap above 4 cycles
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    addr <= a;
    dq_in <= d;
    chip_sel_n <= 1'b0;
    second_select_hi <= 1'b1;
    wr_en_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    wr_en_n <= 1'b1;
    chip_sel_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    // released data shows the inverse, never a stale copy
    dq_in <= ~d;
  endtask
  // ctl is {chip_sel_n, second_select_hi, out_en_n} as pin levels
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [2:0] ctl,
                    output logic [DATA_W-1:0] q, output logic oe);
    @(posedge sys_clk);
    addr <= a;
    {chip_sel_n, second_select_hi, out_en_n} <= ctl;
    repeat (8) @(posedge sys_clk);
    // sample mid-cycle, away from the edge that updates the outputs
    @(negedge sys_clk);
    q = dq_out;
    oe = dq_oe;
    @(posedge sys_clk);
    chip_sel_n <= 1'b1;
    out_en_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the byte-wide rtc
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import brtc_pkg::*;
  localparam int TICK = 200;
  logic              sys_clk, srst, power_ok, chip_sel_n, second_select_hi;
  logic              out_en_n, wr_en_n, dq_oe, oe;
  logic [ADDR_W-1:0] addr, ra;
  logic [DATA_W-1:0] dq_in, dq_out, q, rd_v, yr;
  logic [7:0]        ev [8];
  int                fails, n_tests, seed, t0;
  int                cyc_n = 0;
  brtc_top #(.TICK_CYCLES(TICK), .LOCK_CYCLES(8)) uut (.sys_clk(sys_clk), .srst(srst),
    .power_ok(power_ok), .chip_sel_n(chip_sel_n), .second_select_hi(second_select_hi),
    .out_en_n(out_en_n), .wr_en_n(wr_en_n), .addr(addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));
  brtc_host host (.sys_clk(sys_clk), .dq_out(dq_out), .dq_oe(dq_oe),
    .chip_sel_n(chip_sel_n), .second_select_hi(second_select_hi),
    .out_en_n(out_en_n), .wr_en_n(wr_en_n), .addr(addr), .dq_in(dq_in));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // whole run is well under 10000 cycles
  always @(posedge sys_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      fails = fails + 1;
      close_out();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // 23:59:59 on the 28th of february, one second before midnight
  task automatic set_time(input logic [7:0] y);
    ev = '{8'h00, 8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, y};
    host.wr(CLK_BASE, 8'h80);
    for (int i = 1; i < 8; i++) begin
      host.wr(CLK_BASE + 13'(i), ev[i]);
    end
    host.wr(CLK_BASE, 8'h15);
    t0 = cyc_n;
  endtask
  // sample mid-second so bus latency never straddles a tick
  task automatic mid_tick();
    while ((cyc_n - t0) % TICK != TICK / 2) begin
      @(posedge sys_clk);
    end
  endtask
  task automatic rdc(input logic [2:0] r, input logic [7:0] exp);
    host.rd(CLK_BASE + 13'(r), 3'b010, q, oe);
    check((r == REG_CTRL) ? {2'b00, q[5:0]} : q, exp);
  endtask
  initial begin
    seed = 67;
    fails = 0;
    n_tests = 0;
    srst = 1'b1;
    power_ok = 1'b1;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (30) @(posedge sys_clk);
    // ----------------
    // ram corners and random cells
    // ----------------
    for (int i = 0; i < 8; i++) begin
      ra = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1ff7 : 13'($unsigned($random(seed)) % 8184);
      rd_v = 8'($random(seed));
      host.wr(ra, rd_v);
      host.rd(ra, 3'b010, q, oe);
      check(q, rd_v);
    end
    for (int c = 0; c < 8; c++) begin
      host.rd(ra, 3'(c), q, oe);
      check({7'h00, oe}, {7'h00, c == 2});
    end
    // ----------------
    // power fail and lockout
    // ----------------
    power_ok <= 1'b0;
    repeat (10) @(posedge sys_clk);
    host.wr(ra, ~rd_v);
    host.rd(ra, 3'b010, q, oe);
    check({7'h00, oe}, 8'h00);
    power_ok <= 1'b1;
    host.rd(ra, 3'b010, q, oe);
    check({7'h00, oe}, 8'h00);
    repeat (20) @(posedge sys_clk);
    host.rd(ra, 3'b010, q, oe);
    check(q, rd_v);
    // ----------------
    // midnight rollover, plain and leap year
    // ----------------
    for (int k = 0; k < 2; k++) begin
      yr = (k == 0) ? 8'h99 : 8'h04;
      set_time(yr);
      rdc(REG_CTRL, 8'h15);
      repeat (TICK) @(posedge sys_clk);
      mid_tick();
      host.wr(CLK_BASE, 8'h40);
      ev = '{8'h15, 8'h00, 8'h00, 8'h00, 8'h01, (k == 0) ? 8'h01 : 8'h29,
             (k == 0) ? 8'h03 : 8'h02, yr};
      for (int i = 0; i < 8; i++) begin
        rdc(3'(i), ev[i]);
      end
      if (k == 0) begin
        repeat (2 * TICK) @(posedge sys_clk);
        rdc(REG_SEC, 8'h00);
        host.wr(CLK_BASE, 8'h00);
        mid_tick();
        rdc(REG_SEC, 8'((cyc_n - t0) / TICK - 1));
        rdc(REG_CTRL, 8'h15);
      end
    end
    close_out();
  end
endmodule
`default_nettype wire
